// File: hips_pkg.sv
// constants, register map and state type for the hot-insertion host controller
// assumes a 100 MHz clock and a device that is driven only through its pins
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package hips_pkg;

   // -------------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned RESET_HOLD_US  = 120;
   // least time, so round up to whole cycles
   localparam int unsigned RESET_HOLD_CYC =
      (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_W         = 14;

   // -------------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------------
   localparam int unsigned ADDR_W      = 4;
   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_CMD    = 4'h4;
   localparam logic [3:0]  ADDR_STATUS = 4'h8;
   localparam logic [3:0]  ADDR_TRIPS  = 4'hC;

   // control fields
   localparam int unsigned CTRL_EN     = 0;
   localparam int unsigned CTRL_AUTO   = 1;
   localparam int unsigned CTRL_EXT    = 2;
   localparam int unsigned CTRL_PGLOW  = 3;
   localparam int unsigned CTRL_W      = 4;
   localparam logic [3:0]  CTRL_RST    = 4'h0;

   // command fields
   localparam int unsigned CMD_RESTART = 0;

   // status fields
   localparam int unsigned STS_ON      = 0;
   localparam int unsigned STS_FLTLOW  = 1;
   localparam int unsigned STS_PGOOD   = 2;
   localparam int unsigned STS_RAILS   = 3;
   localparam int unsigned STS_TRIP    = 4;
   localparam int unsigned STS_HOLD    = 5;

   localparam int unsigned TRIPS_W     = 8;

   // -------------------------------------------------------------------------
   // pin filter lanes and reset values
   // -------------------------------------------------------------------------
   localparam int unsigned PIN_W       = 2;
   localparam int unsigned PIN_FAULT   = 0;
   localparam int unsigned PIN_RAILS   = 1;
   localparam logic [1:0]  PIN_RST     = 2'h1;   // fault idles high, rails low

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HOLD,
      ST_ON,
      ST_TRIPPED
   } hips_state_t;

endpackage

// File: hips_pin_if.sv
// bundle between the controller and its pin input filter
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface hips_pin_if;
   logic [1:0] raw;     // pins as they arrive
   logic [1:0] clean;   // filtered levels

   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// File: hips_pin_filter.sv
// three-stage synchroniser with agreement filter for each pin input
// assumes asynchronous pin levels; reset values come from the package
`timescale 1ns/100ps
module hips_pin_filter (
   input  wire logic    clk,      // 100 MHz clock
   input  wire logic    resetn,   // async reset, active low
   hips_pin_if.filt     pins      // raw in, clean out
);

   logic [1:0] s1_ff;
   logic [1:0] s2_ff;
   logic [1:0] s3_ff;
   logic [1:0] clean_ff;

   // ------------------------------------------------------------------------
   // per-pin chain
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < hips_pkg::PIN_W; i++) begin : g_pin
      // s1 feeds only s2; a change counts once s2 and s3 agree
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            s1_ff[i]    <= hips_pkg::PIN_RST[i];
            s2_ff[i]    <= hips_pkg::PIN_RST[i];
            s3_ff[i]    <= hips_pkg::PIN_RST[i];
            clean_ff[i] <= hips_pkg::PIN_RST[i];
         end else begin
            s1_ff[i] <= pins.raw[i];
            s2_ff[i] <= s1_ff[i];
            s3_ff[i] <= s2_ff[i];
            if (s2_ff[i] == s3_ff[i]) begin
               clean_ff[i] <= s2_ff[i];
            end
         end
      end
   end

   assign pins.clean = clean_ff;

endmodule // hips_pin_filter

// File: hips_host_ctrl.sv
// host controller for a hot-insertion power sequencer: drives the on input,
// the open-drain fault line and the open-drain power-good line
// assumes software on a plain register port and a 100 MHz clock
`timescale 1ns/100ps
module hips_host_ctrl #(
   parameter int unsigned RESET_HOLD_CYC = hips_pkg::RESET_HOLD_CYC  // on-low hold
) (
   input  wire logic        clk,          // 100 MHz clock
   input  wire logic        resetn,       // async reset, active low
   input  wire logic [3:0]  regAddr,      // register byte address
   input  wire logic [31:0] regWdata,     // write data
   input  wire logic        regWe,        // write strobe
   input  wire logic        regRe,        // read strobe
   output logic      [31:0] regRdata,     // read data, cycle after strobe
   input  wire logic        railsOk,      // board converters in regulation
   input  wire logic        faultPinIn,   // fault line level
   output logic             faultPinOut,  // fault line drive value
   output logic             faultPinOe,   // fault line pull-down enable
   output logic             onPin,        // on input of the device
   output logic             pgPinOut,     // power-good line drive value
   output logic             pgPinOe       // power-good pull-down enable
);

   hips_pin_if pinBus ();

   logic [3:0]               ctrl_ff;
   logic                     restartCmd;
   logic                     stsClrTrip;
   hips_pkg::hips_state_t    state_ff;
   hips_pkg::hips_state_t    nxt_state;
   logic [13:0]              holdCnt_ff;
   logic                     tripSeen_ff;
   logic [7:0]               trips_ff;
   logic [31:0]              rdata_ff;
   logic                     on_ff;
   logic                     fltOe_ff;
   logic                     fltOut_ff;
   logic                     pgOe_ff;
   logic                     pgOut_ff;
   logic                     faultLow;
   logic                     railsSync;
   logic                     holdDone;
   logic                     enable;
   logic                     autoRetry;
   logic                     extTrip;
   logic                     pgForceLow;

   // ------------------------------------------------------------------------
   // pin filtering
   // ------------------------------------------------------------------------
   assign pinBus.raw[hips_pkg::PIN_FAULT] = faultPinIn;
   assign pinBus.raw[hips_pkg::PIN_RAILS] = railsOk;

   hips_pin_filter u_filter (
      .clk    (clk),
      .resetn (resetn),
      .pins   (pinBus.filt)
   );

   assign faultLow  = !pinBus.clean[hips_pkg::PIN_FAULT];
   assign railsSync = pinBus.clean[hips_pkg::PIN_RAILS];

   // ------------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------------
   assign enable     = ctrl_ff[hips_pkg::CTRL_EN];
   assign autoRetry  = ctrl_ff[hips_pkg::CTRL_AUTO];
   assign extTrip    = ctrl_ff[hips_pkg::CTRL_EXT];
   assign pgForceLow = ctrl_ff[hips_pkg::CTRL_PGLOW];
   assign restartCmd = regWe && (regAddr == hips_pkg::ADDR_CMD)
                       && regWdata[hips_pkg::CMD_RESTART];
   assign stsClrTrip = regWe && (regAddr == hips_pkg::ADDR_STATUS)
                       && regWdata[hips_pkg::STS_TRIP];

   // control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= hips_pkg::CTRL_RST;
      end else if (regWe && (regAddr == hips_pkg::ADDR_CTRL)) begin
         ctrl_ff <= regWdata[3:0];
      end
   end

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (regRe) begin
         case (regAddr)
            hips_pkg::ADDR_CTRL: begin
               rdata_ff <= {28'h000_0000, ctrl_ff};
            end
            hips_pkg::ADDR_STATUS: begin
               rdata_ff <= {26'h000_0000, (state_ff == hips_pkg::ST_HOLD),
                            tripSeen_ff, railsSync, !pgOe_ff, faultLow, on_ff};
            end
            hips_pkg::ADDR_TRIPS: begin
               rdata_ff <= {24'h00_0000, trips_ff};
            end
            default: begin
               rdata_ff <= 32'h0000_0000;   // command and unmapped read zero
            end
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------------
   // on-input sequencer
   // ------------------------------------------------------------------------
   assign holdDone = (holdCnt_ff == 14'(RESET_HOLD_CYC - 1));

   // every reconnect passes through the hold, so the breaker is always reset
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         hips_pkg::ST_IDLE: begin
            if (enable) begin
               nxt_state = hips_pkg::ST_HOLD;
            end
         end
         hips_pkg::ST_HOLD: begin
            if (!enable) begin
               nxt_state = hips_pkg::ST_IDLE;
            end else if (holdDone) begin
               nxt_state = hips_pkg::ST_ON;
            end
         end
         hips_pkg::ST_ON: begin
            if (!enable) begin
               nxt_state = hips_pkg::ST_IDLE;
            end else if (faultLow) begin
               nxt_state = hips_pkg::ST_TRIPPED;
            end
         end
         hips_pkg::ST_TRIPPED: begin
            if (!enable) begin
               nxt_state = hips_pkg::ST_IDLE;
            end else if (restartCmd || autoRetry) begin
               nxt_state = hips_pkg::ST_HOLD;
            end
         end
         default: begin
            nxt_state = hips_pkg::ST_IDLE;
         end
      endcase
   end

   // state and on pin; on follows the next state so both move together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= hips_pkg::ST_IDLE;
         on_ff    <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         on_ff    <= (nxt_state == hips_pkg::ST_ON)
                     || (nxt_state == hips_pkg::ST_TRIPPED);
      end
   end

   // on-low hold counter, cleared outside the hold
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         holdCnt_ff <= 14'h0000;
      end else if ((state_ff == hips_pkg::ST_HOLD) && !holdDone) begin
         holdCnt_ff <= holdCnt_ff + 14'h0001;
      end else begin
         holdCnt_ff <= 14'h0000;
      end
   end

   // ------------------------------------------------------------------------
   // trip bookkeeping
   // ------------------------------------------------------------------------
   // a trip arriving with the clear still sets the flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tripSeen_ff <= 1'b0;
      end else if ((state_ff == hips_pkg::ST_ON) && faultLow) begin
         tripSeen_ff <= 1'b1;
      end else if (stsClrTrip) begin
         tripSeen_ff <= 1'b0;
      end
   end

   // trip count saturates rather than wrapping to a misleading small value
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trips_ff <= 8'h00;
      end else if ((state_ff == hips_pkg::ST_ON) && faultLow && (trips_ff != 8'hFF)) begin
         trips_ff <= trips_ff + 8'h01;
      end
   end

   // ------------------------------------------------------------------------
   // open-drain pin drive
   // ------------------------------------------------------------------------
   // fault line pulled low on demand; power good released once rails settle while on is high and not forced low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fltOe_ff  <= 1'b0;
         fltOut_ff <= 1'b0;
         pgOe_ff   <= 1'b1;
         pgOut_ff  <= 1'b0;
      end else begin
         fltOe_ff  <= extTrip;
         fltOut_ff <= 1'b0;
         pgOe_ff   <= !(railsSync && on_ff && !pgForceLow);
         pgOut_ff  <= 1'b0;
      end
   end

   assign regRdata    = rdata_ff;
   assign faultPinOut = fltOut_ff;
   assign faultPinOe  = fltOe_ff;
   assign onPin       = on_ff;
   assign pgPinOut    = pgOut_ff;
   assign pgPinOe     = pgOe_ff;

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   logic [13:0] lowRun_ff;

   // consecutive cycles with on low, saturating at full scale
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lowRun_ff <= 14'h0000;
      end else if (on_ff) begin
         lowRun_ff <= 14'h0000;
      end else if (lowRun_ff != 14'h3FFF) begin
         lowRun_ff <= lowRun_ff + 14'h0001;
      end
   end

   sequence s_tripped_retry;
      (state_ff == hips_pkg::ST_TRIPPED) && enable && (autoRetry || restartCmd);
   endsequence

   sequence s_on_low_pair;
      !on_ff [*2];
   endsequence

   sequence s_trip_event;
      (state_ff == hips_pkg::ST_ON) && enable && faultLow;
   endsequence

   a_hold_before_on: assert property (@(posedge clk) disable iff (!resetn)
      $rose(on_ff) |-> (lowRun_ff >= 14'(RESET_HOLD_CYC)))
      else $error("on raised before full reset hold");

   a_retry_drops_on: assert property (@(posedge clk) disable iff (!resetn)
      s_tripped_retry |=> s_on_low_pair)
      else $error("retry did not drop on input");

   a_trip_seen_set: assert property (@(posedge clk) disable iff (!resetn)
      s_trip_event |=> tripSeen_ff && on_ff)
      else $error("fault low while on not recorded");

   a_ext_trip_drive: assert property (@(posedge clk) disable iff (!resetn)
      $rose(extTrip) |=> faultPinOe && !faultPinOut)
      else $error("external trip not driven on fault line");

   a_pg_release: assert property (@(posedge clk) disable iff (!resetn)
      (railsSync && on_ff && !pgForceLow) [*2] |-> !pgPinOe)
      else $error("power good held low with rails ok");

   a_pg_hold_low: assert property (@(posedge clk) disable iff (!resetn)
      !on_ff |=> pgPinOe)
      else $error("power good released with on low");

   // sequencer and pin drive invariants; the hold is the only path to on high
   a_enable_drop_on: assert property (@(posedge clk) disable iff (!resetn)
      !enable |=> !on_ff)
      else $error("on stayed high with enable clear");

   a_hold_on_low: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == hips_pkg::ST_HOLD) |-> !on_ff)
      else $error("on high during reset hold");

   a_hold_then_on: assert property (@(posedge clk) disable iff (!resetn)
      ((state_ff == hips_pkg::ST_HOLD) && holdDone && enable) |=> on_ff)
      else $error("on not raised after full hold");

   a_hold_cnt_range: assert property (@(posedge clk) disable iff (!resetn)
      holdCnt_ff <= 14'(RESET_HOLD_CYC - 1))
      else $error("hold counter ran past its end");

   a_tripped_on_high: assert property (@(posedge clk) disable iff (!resetn)
      (state_ff == hips_pkg::ST_TRIPPED) |-> on_ff)
      else $error("on dropped while tripped without restart");

   a_trip_count_step: assert property (@(posedge clk) disable iff (!resetn)
      ((state_ff == hips_pkg::ST_ON) && faultLow && (trips_ff != 8'hFF))
      |=> (trips_ff == $past(trips_ff) + 8'h01))
      else $error("trip count did not advance");

   a_pg_force_low: assert property (@(posedge clk) disable iff (!resetn)
      pgForceLow |=> pgPinOe)
      else $error("power good released while forced low");

   a_ext_trip_hold: assert property (@(posedge clk) disable iff (!resetn)
      extTrip |=> (faultPinOe && !faultPinOut))
      else $error("fault line not held low for external trip");

   a_ext_trip_free: assert property (@(posedge clk) disable iff (!resetn)
      !extTrip |=> !faultPinOe)
      else $error("fault line pulled without external trip");

endmodule // hips_host_ctrl

// File: hips_dev_model.sv
// behavioural model of the hot-insertion sequencer as seen at its pins
// assumes the controller's clock; supply lockout low doubles as its reset
`timescale 1ns/100ps
module hips_dev_model #(
   parameter int unsigned TMR_CYC  = 8,     // one system timing cycle
   parameter int unsigned RAMP_CYC = 2,     // one timeout ramp cycle
   parameter int unsigned FILT_CYC = 6,     // glitch filter delay
   parameter int unsigned SLOW_CYC = 1800,  // 18 us slow qualification
   parameter int unsigned FAST_CYC = 50,    // 500 ns fast qualification
   parameter int unsigned BRK_CYC  = 3      // on-low time to clear breaker
) (
   input  wire logic clk,       // shared clock
   input  wire logic supplyOk,  // supply above lockout
   input  wire logic onIn,      // on input level
   input  wire logic faultIn,   // fault wire level
   input  wire logic pgIn,      // power good wire level
   input  wire logic slowOc,    // sense drop above low threshold
   input  wire logic fastOc,    // sense drop above high threshold
   output logic      faultOe,   // pull fault wire low
   output logic      gateOn,    // pass switch driven
   output logic      tripped    // breaker latched
);
   localparam int P_OFF = 0;
   localparam int P_T1  = 1;
   localparam int P_WT  = 2;
   localparam int P_T2  = 3;
   localparam int P_TO  = 4;
   localparam int P_RUN = 5;

   int   phase_ff = 0;
   int   tmr_ff   = 0;
   int   pgt_ff   = 0;
   int   onLow_ff = 0;
   int   slow_ff  = 0;
   int   fast_ff  = 0;
   int   filt_ff  = 0;
   logic brk_ff   = 1'b0;
   logic trip;

   // qualification counters, cleared as soon as the condition lapses
   always_ff @(posedge clk) begin
      onLow_ff <= onIn ? 0 : onLow_ff + 1;
      slow_ff  <= (slowOc && phase_ff != P_OFF) ? slow_ff + 1 : 0;
      fast_ff  <= (fastOc && phase_ff != P_OFF) ? fast_ff + 1 : 0;
      filt_ff  <= (phase_ff == P_RUN && !pgIn) ? filt_ff + 1 : 0;
   end

   // trip sources; fault low only counts once the switch is driven
   assign trip = slow_ff >= SLOW_CYC
              || fast_ff > FAST_CYC
              || filt_ff > FILT_CYC
              || (phase_ff == P_TO && pgt_ff == 14 * RAMP_CYC - 1 && !pgIn)
              || (phase_ff >= P_T2 && !faultIn);

   // sequence and breaker; lockout and on-low both fall back to idle
   always_ff @(posedge clk) begin
      if (!supplyOk || onLow_ff >= 1) begin
         phase_ff <= P_OFF;
         tmr_ff   <= 0;
         pgt_ff   <= 0;
         if (!supplyOk || onLow_ff >= BRK_CYC)
            brk_ff <= 1'b0;
      end else if (brk_ff || trip) begin
         brk_ff   <= 1'b1;
         phase_ff <= P_OFF;
         tmr_ff   <= 0;
         pgt_ff   <= 0;
      end else begin
         case (phase_ff)
            P_OFF: if (onIn) phase_ff <= P_T1;
            P_T1, P_T2: begin
               tmr_ff <= (tmr_ff == TMR_CYC - 1) ? 0 : tmr_ff + 1;
               if (tmr_ff == TMR_CYC - 1)
                  phase_ff <= (phase_ff == P_T2) ? P_TO : faultIn ? P_T2 : P_WT;
            end
            P_WT: if (faultIn) phase_ff <= P_T2;
            P_TO: begin
               pgt_ff <= pgt_ff + 1;
               if (pgt_ff == 14 * RAMP_CYC - 1) phase_ff <= P_RUN;
            end
            default: ;
         endcase
      end
   end

   // gate drops in the same cycle as a trip, not a cycle later
   assign gateOn  = supplyOk && !brk_ff && !trip && phase_ff >= P_T2;
   assign faultOe = brk_ff;
   assign tripped = brk_ff;
endmodule // hips_dev_model

// File: tb.sv
// self-checking bench: host controller driving the sequencer model
// assumes package, pin interface and controller files are compiled first
`timescale 1ns/100ps
module tb;
   localparam int HOLD = 12;
   typedef struct {
      logic [3:0]  a;
      logic [31:0] w;
      logic [31:0] r;
      logic        oe;
   } hips_row_t;

   logic        clk      = 1'b0;
   logic        resetn   = 1'b0;
   logic [3:0]  regAddr  = 4'h0;
   logic [31:0] regWdata = 32'h0000_0000;
   logic        regWe    = 1'b0;
   logic        regRe    = 1'b0;
   logic        railsOk  = 1'b0;
   logic        supplyOk = 1'b0;
   logic        slowOc   = 1'b0;
   logic        fastOc   = 1'b0;
   logic [31:0] regRdata;
   logic        faultPinOut, faultPinOe, onPin, pgPinOut, pgPinOe;
   logic        devFaultOe, gateOn, tripped;
   wire         faultWire = !(faultPinOe || devFaultOe);  // pulled up
   wire         pgWire    = !pgPinOe;                     // pulled up
   int          nMismatch = 0;
   int          totalChecks = 0;
   int          n;
   logic [31:0] d;
   hips_row_t   rows [6] = '{
      '{hips_pkg::ADDR_CTRL,  32'hFFFF_FFF4, 32'h0000_0004, 1'b1},
      '{hips_pkg::ADDR_CTRL,  32'h0000_0008, 32'h0000_0008, 1'b0},
      '{hips_pkg::ADDR_CMD,   32'h0000_0001, 32'h0000_0000, 1'b0},
      '{hips_pkg::ADDR_TRIPS, 32'h0000_00FF, 32'h0000_0000, 1'b0},
      '{4'h2,                 32'hFFFF_FFF0, 32'h0000_0000, 1'b0},
      '{hips_pkg::ADDR_CTRL,  32'h0000_0000, 32'h0000_0000, 1'b0}};

   always #5 clk = ~clk;

   hips_host_ctrl #(.RESET_HOLD_CYC(HOLD)) uut (.clk(clk), .resetn(resetn),
      .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
      .regRdata(regRdata), .railsOk(railsOk), .faultPinIn(faultWire),
      .faultPinOut(faultPinOut), .faultPinOe(faultPinOe), .onPin(onPin),
      .pgPinOut(pgPinOut), .pgPinOe(pgPinOe));
   hips_dev_model model (.clk(clk), .supplyOk(supplyOk), .onIn(onPin),
      .faultIn(faultWire), .pgIn(pgWire), .slowOc(slowOc), .fastOc(fastOc),
      .faultOe(devFaultOe), .gateOn(gateOn), .tripped(tripped));

   // ------------------------------------------------------------------
   // helpers; every task returns 1 ns after an edge, outputs settled
   // ------------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] w);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= w;
      regWe    <= 1'b1;
      @(posedge clk);
      regWe    <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRe   <= 1'b1;
      @(posedge clk);
      regRe   <= 1'b0;
      #1;
      v = regRdata;
   endtask
   function automatic logic sigOf(input int s);
      case (s)
         0: return gateOn;
         1: return faultWire;
         2: return onPin;
         default: return tripped;
      endcase
   endfunction
   // bounded wait; n keeps the cycles spent for timing checks
   task automatic waitFor(input int s, input logic v);
      n = 0;
      while (sigOf(s) !== v && n < 3000) begin
         tick(1);
         n++;
      end
      if (n >= 3000) nMismatch++;  // a wait that runs out is a failure
   endtask
   task automatic pulse(input int k, input int len);
      @(posedge clk);
      slowOc <= (k == 0);
      fastOc <= (k == 1);
      repeat (len) @(posedge clk);
      slowOc <= 1'b0;
      fastOc <= 1'b0;
      #1;
   endtask
   task automatic restart;
      tick(6);  // let the filtered fault reach the controller first
      wr(hips_pkg::ADDR_CMD, 32'h0000_0001);
      waitFor(3, 1'b0);
      waitFor(0, 1'b1);
      ck(gateOn, 1'b1);
      tick(45);
   endtask
   task automatic testDone;
      $display("checks %0d, mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // reset, register rows, then the sequenced cases
   // ------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
   end
   initial begin
      tick(6);
      ck(onPin, 1'b0);
      ck(pgPinOe, 1'b1);
      ck(faultPinOe, 1'b0);
      ck(faultPinOut, 1'b0);
      ck(pgPinOut, 1'b0);
      ck(regRdata, 32'h0000_0000);
      tick(8);
      @(posedge clk) supplyOk <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         tick(1);
         ck(faultPinOe, rows[i].oe);
         rd(rows[i].a, d);
         ck(d, rows[i].r);
      end
      @(posedge clk) railsOk <= 1'b1;
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0001);
      waitFor(2, 1'b1);
      ck(n >= HOLD, 1'b1);
      waitFor(0, 1'b1);
      ck(n >= 8, 1'b1);
      tick(45);
      ck(tripped, 1'b0);
      rd(hips_pkg::ADDR_STATUS, d);
      ck(d, 32'h0000_000D);
      // a short power-good dip must pass, a long one must trip
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0009);
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0001);
      tick(10);
      ck(tripped, 1'b0);
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0009);
      waitFor(1, 1'b0);
      ck(n > 6, 1'b1);
      ck(gateOn, 1'b0);
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0001);
      tick(6);
      rd(hips_pkg::ADDR_STATUS, d);
      ck(d, 32'h0000_001F);
      restart;
      wr(hips_pkg::ADDR_STATUS, 32'h0000_0010);
      rd(hips_pkg::ADDR_STATUS, d);
      ck(d, 32'h0000_000D);
      // overcurrent just under and just over each qualification time
      for (int k = 0; k < 2; k++) begin
         pulse(k, k ? 50 : 1799);
         tick(3);
         ck(tripped, 1'b0);
         pulse(k, k ? 60 : 1810);
         tick(3);
         ck(tripped, 1'b1);
         ck(faultWire, 1'b0);
         restart;
      end
      @(posedge clk) supplyOk <= 1'b0;
      tick(2);
      ck(gateOn, 1'b0);
      @(posedge clk) supplyOk <= 1'b1;
      waitFor(0, 1'b1);
      ck(gateOn, 1'b1);
      tick(45);
      // rails lost: filter trip, then a restart that times out
      @(posedge clk) railsOk <= 1'b0;
      waitFor(1, 1'b0);
      ck(tripped, 1'b1);
      tick(6);
      wr(hips_pkg::ADDR_CMD, 32'h0000_0001);
      waitFor(0, 1'b1);
      waitFor(1, 1'b0);
      ck(n >= 35, 1'b1);
      @(posedge clk) railsOk <= 1'b1;
      restart;
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0005);
      waitFor(3, 1'b1);
      ck(gateOn, 1'b0);
      tick(6);
      rd(hips_pkg::ADDR_TRIPS, d);
      ck(d, 32'h0000_0006);
      // automatic retry out of the tripped state
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0003);
      waitFor(0, 1'b1);
      ck(gateOn, 1'b1);
      wr(hips_pkg::ADDR_CTRL, 32'h0000_0000);
      tick(2);
      ck(onPin, 1'b0);
      testDone;
   end

   // watchdog well beyond the longest expected run
   initial begin
      repeat (30000) @(posedge clk);
      nMismatch++;
      testDone;
   end
endmodule // tb
